/* File: rtl/sss_defines.svh */
// constants of the step sequencer: offsets, field positions, reset values, timing counts
// assumes a 50 MHz core clock; included by the sequencer module
//
// Functional notes
// - LLL full step balanced, HLL full step full ratio, LHL half 1-2, HHL half full.
// - microstep: LLH quarter, HLH eighth, LHH sixteenth, HHH deep sleep.
// - deep sleep disables outputs and step edges do not move the position.
// - monitor output high at two-phase positions on microstep variants, else low.
// - fault flag high while protection is active, low in normal operation.
// - all outputs turn off as soon as a protection event begins.
// - protection stays latched until the logic supply is cycled.
// - step, reset, direction, mode and sync inputs are noise filtered first.
// - one step per rising step edge; dual-edge variant steps on both edges.
// - direction and mode pins only take effect at a step edge, except the deep sleep code, which disables outputs at once.
// - direction level picks forward or backward stepping.
// - a mode change maps the current position onto the new mode's grid.
// - full ratio gives 100 percent current and a 12 us chopper off time.
// - each phase current reference follows the sequencer position.
// - off time and blanking of each phase come from an internal timebase.
// - with chop sync high, one common signal chops both phases together.
// - coil open faults count only while chopping; they trip protection.
// - over-temperature shutdown disables outputs until the supply is cycled.
// - reset pin high restarts excitation from the initial position.
// - light sleep disables outputs but steps still move the position.
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SSS_CLK_NS        20
`define SSS_FILT_NS       100
`define SSS_FILT_CYC      ((`SSS_FILT_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_BLANK_NS      1700
`define SSS_BLANK_CYC     ((`SSS_BLANK_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_OFF_FULL_NS   12000
`define SSS_OFF_FULL_CYC  ((`SSS_OFF_FULL_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_OFF_PART_NS   8000
`define SSS_OFF_PART_CYC  ((`SSS_OFF_PART_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)

// ----------------------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------------------
`define SSS_POS_INIT      6'h08
`define SSS_TWO_PHASE_IDX 4'h8
`define SSS_RATIO_FULL    8'hff

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define SSS_ADDR_CTRL     8'h00
`define SSS_ADDR_STATUS   8'h04
`define SSS_CTRL_SOFT_OFF 0
`define SSS_CTRL_RST      1'b0
`define SSS_RESP_OKAY     2'h0
`define SSS_RESP_DECERR   2'h3

`endif

/* File: rtl/sss_pkg.sv */
// types of the step sequencer
// assumes it is compiled before any module that imports it
`default_nettype none
package sss_pkg;

  // gray along full -> half -> micro -> sleep
  typedef enum logic [2:0] {
    SSS_MODE_FULL8  = 3'h0,
    SSS_MODE_FULLF  = 3'h1,
    SSS_MODE_HALF12 = 3'h3,
    SSS_MODE_HALFF  = 3'h2,
    SSS_MODE_QUART  = 3'h6,
    SSS_MODE_EIGHTH = 3'h7,
    SSS_MODE_SIXT   = 3'h5,
    SSS_MODE_SLEEP  = 3'h4
  } sss_mode_t;

  typedef enum logic [1:0] {
    SSS_CHOP_BLANK = 2'h0,
    SSS_CHOP_ON    = 2'h1,
    SSS_CHOP_OFF   = 2'h3
  } sss_chop_t;

  typedef struct packed {
    logic       drive;
    logic       neg;
    logic [7:0] ratio;
  } sss_phase_t;

  typedef struct packed {
    logic [12:0]      s1;
    logic [12:0]      s2;
    logic [6:0]       filt;
    logic [6:0][2:0]  fcnt;
    logic             step_prev;
    logic [5:0]       pos;
    sss_mode_t        mode;
    logic             fault;
    logic             en;
    logic             mon;
    sss_chop_t [1:0]  chop;
    logic [1:0][9:0]  ccnt;
    logic             sync_off;
    logic             sync_pulse;
    sss_phase_t [1:0] ph;
    logic             soft_off;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sss_state_t;

endpackage

`default_nettype wire

/* File: rtl/sss_step_sequencer.sv */
// step sequencer, chopper timing and protection latch of a two-phase stepper driver
// assumes pin inputs are asynchronous; rst_n_i stands for the logic supply cycle
`timescale 1ns/1ps
`default_nettype none
`include "sss_defines.svh"

module sss_step_sequencer
  import sss_pkg::*;
#(
  parameter bit MICROSTEP = 1'b1,
  parameter bit DUAL_EDGE = 1'b0
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        step_clock_i,
  input  wire logic        reset_pin_i,
  input  wire logic        direction_select_i,
  input  wire logic        mode_select_0_i,
  input  wire logic        mode_select_1_i,
  input  wire logic        mode_select_2_i,
  input  wire logic        chop_sync_i,
  input  wire logic        current_reference_sleep_input_i,
  input  wire logic [1:0]  current_trip_i,
  input  wire logic [1:0]  coil_open_i,
  input  wire logic        over_temperature_shutdown_i,
  output var  sss_phase_t  phase_a_o,
  output var  sss_phase_t  phase_b_o,
  output logic             outputs_enable_o,
  output logic             two_phase_monitor_o,
  output logic             fault_flag_o,
  output logic             chop_sync_pulse_o,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic sss_mode_t decode_mode(input logic [2:0] m);
    sss_mode_t r;
    r = SSS_MODE_SLEEP;
    unique case (m)
      3'h0: r = SSS_MODE_FULL8;
      3'h1: r = SSS_MODE_FULLF;
      3'h2: r = SSS_MODE_HALF12;
      3'h3: r = SSS_MODE_HALFF;
      3'h4: r = MICROSTEP ? SSS_MODE_QUART : SSS_MODE_SLEEP;
      3'h5: r = MICROSTEP ? SSS_MODE_EIGHTH : SSS_MODE_SLEEP;
      3'h6: r = MICROSTEP ? SSS_MODE_SIXT : SSS_MODE_SLEEP;
      3'h7: r = SSS_MODE_SLEEP;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] mode_inc(input sss_mode_t m);
    logic [5:0] r;
    r = 6'h10;
    unique case (m)
      SSS_MODE_FULL8, SSS_MODE_FULLF, SSS_MODE_SLEEP: r = 6'h10;
      SSS_MODE_HALF12, SSS_MODE_HALFF:                r = 6'h08;
      SSS_MODE_QUART:                                 r = 6'h04;
      SSS_MODE_EIGHTH:                                r = 6'h02;
      SSS_MODE_SIXT:                                  r = 6'h01;
    endcase
    return r;
  endfunction

  // snap onto the grid of the new mode; full step lives on the two-phase points
  function automatic logic [5:0] map_pos(input logic [5:0] p, input sss_mode_t m);
    logic [5:0] r;
    r = p;
    unique case (m)
      SSS_MODE_FULL8, SSS_MODE_FULLF, SSS_MODE_SLEEP: r = {p[5:4], `SSS_TWO_PHASE_IDX};
      SSS_MODE_HALF12, SSS_MODE_HALFF:                r = {p[5:3], 3'h0};
      SSS_MODE_QUART:                                 r = {p[5:2], 2'h0};
      SSS_MODE_EIGHTH:                                r = {p[5:1], 1'h0};
      SSS_MODE_SIXT:                                  r = p;
    endcase
    return r;
  endfunction

  // quarter sine in sixteenths; index 8 is the balanced two-phase level
  function automatic logic [7:0] sine_q(input logic [4:0] k);
    logic [7:0] r;
    r = 8'hff;
    unique case (k)
      5'h00: r = 8'h00;
      5'h01: r = 8'h19;
      5'h02: r = 8'h32;
      5'h03: r = 8'h4a;
      5'h04: r = 8'h62;
      5'h05: r = 8'h78;
      5'h06: r = 8'h8e;
      5'h07: r = 8'ha2;
      5'h08: r = 8'hb4;
      5'h09: r = 8'hc5;
      5'h0a: r = 8'hd4;
      5'h0b: r = 8'he1;
      5'h0c: r = 8'hec;
      5'h0d: r = 8'hf4;
      5'h0e: r = 8'hfa;
      5'h0f: r = 8'hfe;
      default: r = 8'hff;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  sss_state_t q;
  sss_state_t d;

  logic        step_edge;
  sss_mode_t   live_mode;
  logic        deep_sleep;
  logic        light_sleep;
  logic [1:0]  chop_act;
  logic [1:0]  tripped;
  logic        fault_evt;
  logic [12:0] async_in;

  assign async_in = {over_temperature_shutdown_i, coil_open_i, current_trip_i,
                     current_reference_sleep_input_i, chop_sync_i, mode_select_2_i,
                     mode_select_1_i, mode_select_0_i, direction_select_i, reset_pin_i,
                     step_clock_i};

  always_comb begin
    logic [5:0]  base;
    logic [4:0]  ka;
    logic [4:0]  kb;
    logic [7:0]  mag;
    logic [9:0]  off_lim;
    logic        wr_ok;
    d       = q;
    base    = '0;
    ka      = '0;
    kb      = '0;
    mag     = '0;
    off_lim = '0;
    wr_ok   = 1'b0;

    // ----------------------------------------------------------------------
    // input sync and glitch filter: a level must hold several cycles
    // ----------------------------------------------------------------------
    d.s1 = async_in;
    d.s2 = q.s1;
    for (int i = 0; i < 7; i++) begin
      if (q.s2[i] == q.filt[i]) begin
        d.fcnt[i] = '0;
      end else if (q.fcnt[i] == 3'(`SSS_FILT_CYC - 1)) begin
        d.filt[i] = q.s2[i];
        d.fcnt[i] = '0;
      end else begin
        d.fcnt[i] = q.fcnt[i] + 3'h1;
      end
    end

    step_edge   = (q.filt[0] & ~q.step_prev) | (DUAL_EDGE & ~q.filt[0] & q.step_prev);
    d.step_prev = q.filt[0];
    live_mode   = decode_mode(q.filt[5:3]);
    deep_sleep  = (live_mode == SSS_MODE_SLEEP);
    light_sleep = q.s2[7];

    // ----------------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------------
    if (q.filt[1]) begin
      d.pos  = `SSS_POS_INIT;
      d.mode = SSS_MODE_FULL8;
    end else if (step_edge && !deep_sleep) begin
      base   = map_pos(q.pos, live_mode);
      d.mode = live_mode;
      if (q.filt[2]) begin
        d.pos = base - mode_inc(live_mode);
      end else begin
        d.pos = base + mode_inc(live_mode);
      end
    end
    d.mon = MICROSTEP && (d.pos[3:0] == `SSS_TWO_PHASE_IDX);

    // ----------------------------------------------------------------------
    // protection: latched, only the supply reset clears it
    // ----------------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      chop_act[i] = q.en && (q.ph[i].ratio != 8'h00);
    end
    fault_evt = (|(q.s2[11:10] & chop_act)) | q.s2[12];
    d.fault   = q.fault | fault_evt;
    d.en      = !d.fault && !deep_sleep && !light_sleep && !q.soft_off;

    // ----------------------------------------------------------------------
    // current references
    // ----------------------------------------------------------------------
    ka = d.pos[4] ? {1'b0, d.pos[3:0]} : 5'h10 - {1'b0, d.pos[3:0]};
    kb = d.pos[4] ? 5'h10 - {1'b0, d.pos[3:0]} : {1'b0, d.pos[3:0]};
    for (int i = 0; i < 2; i++) begin
      mag = sine_q(i == 0 ? ka : kb);
      if (mag != 8'h00 && (d.mode == SSS_MODE_FULLF || d.mode == SSS_MODE_HALFF ||
          (d.mode == SSS_MODE_HALF12 && d.pos[3:0] != `SSS_TWO_PHASE_IDX))) begin
        mag = `SSS_RATIO_FULL;
      end
      d.ph[i].ratio = mag;
    end
    d.ph[0].neg = d.pos[5] ^ d.pos[4];
    d.ph[1].neg = d.pos[5];

    // ----------------------------------------------------------------------
    // fixed off-time chopper per phase
    // ----------------------------------------------------------------------
    d.sync_pulse = 1'b0;
    for (int i = 0; i < 2; i++) begin
      tripped[i] = chop_act[i] && (q.chop[i] == SSS_CHOP_ON) && q.s2[8 + i];
    end
    if (q.filt[6] && (|tripped)) begin
      for (int i = 0; i < 2; i++) begin
        d.chop[i] = SSS_CHOP_OFF;
        d.ccnt[i] = '0;
      end
      d.sync_off   = 1'b1;
      d.sync_pulse = 1'b1;
    end else begin
      for (int i = 0; i < 2; i++) begin
        off_lim = (q.sync_off || q.ph[i].ratio == `SSS_RATIO_FULL) ?
                  10'(`SSS_OFF_FULL_CYC - 1) : 10'(`SSS_OFF_PART_CYC - 1);
        if (!chop_act[i]) begin
          d.chop[i] = SSS_CHOP_BLANK;
          d.ccnt[i] = '0;
        end else begin
          unique case (q.chop[i])
            SSS_CHOP_BLANK: begin
              d.ccnt[i] = q.ccnt[i] + 10'h001;
              if (q.ccnt[i] == 10'(`SSS_BLANK_CYC - 1)) begin
                d.chop[i] = SSS_CHOP_ON;
                d.ccnt[i] = '0;
              end
            end
            SSS_CHOP_ON: begin
              if (tripped[i]) begin
                d.chop[i] = SSS_CHOP_OFF;
                d.ccnt[i] = '0;
              end
            end
            SSS_CHOP_OFF: begin
              d.ccnt[i] = q.ccnt[i] + 10'h001;
              if (q.ccnt[i] == off_lim) begin
                d.chop[i] = SSS_CHOP_BLANK;
                d.ccnt[i] = '0;
              end
            end
            default: begin
              d.chop[i] = SSS_CHOP_BLANK;
              d.ccnt[i] = '0;
            end
          endcase
        end
      end
      if (d.chop[0] != SSS_CHOP_OFF && d.chop[1] != SSS_CHOP_OFF) begin
        d.sync_off = 1'b0;
      end
    end
    for (int i = 0; i < 2; i++) begin
      d.ph[i].drive = d.en && (d.ph[i].ratio != 8'h00) && (d.chop[i] != SSS_CHOP_OFF);
    end

    // ----------------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------------
    if (s_axi_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      wr_ok    = (q.awaddr == `SSS_ADDR_CTRL) || (q.awaddr == `SSS_ADDR_STATUS);
      d.bresp  = wr_ok ? `SSS_RESP_OKAY : `SSS_RESP_DECERR;
      d.bvalid = 1'b1;
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      if (q.awaddr == `SSS_ADDR_CTRL && q.wstrb[0]) begin
        d.soft_off = q.wdata[`SSS_CTRL_SOFT_OFF];
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = `SSS_RESP_OKAY;
      d.rdata  = '0;
      if (s_axi_araddr == `SSS_ADDR_CTRL) begin
        d.rdata[`SSS_CTRL_SOFT_OFF] = q.soft_off;
      end else if (s_axi_araddr == `SSS_ADDR_STATUS) begin
        d.rdata[11:0] = {q.en, q.fault, q.mon, q.mode, q.pos};
      end else begin
        d.rresp = `SSS_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.pos      <= `SSS_POS_INIT;
      q.soft_off <= `SSS_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign phase_a_o           = q.ph[0];
  assign phase_b_o           = q.ph[1];
  assign outputs_enable_o    = q.en;
  assign two_phase_monitor_o = q.mon;
  assign fault_flag_o        = q.fault;
  assign chop_sync_pulse_o   = q.sync_pulse;
  assign s_axi_awready       = !q.aw_got;
  assign s_axi_wready        = !q.w_got;
  assign s_axi_bvalid        = q.bvalid;
  assign s_axi_bresp         = q.bresp;
  assign s_axi_arready       = !q.rvalid;
  assign s_axi_rvalid        = q.rvalid;
  assign s_axi_rdata         = q.rdata;
  assign s_axi_rresp         = q.rresp;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_active_edge;
    step_edge && !deep_sleep && !q.filt[1];
  endsequence

  sequence s_sixt_fwd;
    s_active_edge ##0 (live_mode == SSS_MODE_SIXT) && !q.filt[2];
  endsequence

  a_fault_latched: assert property (fault_flag_o |=> fault_flag_o [*8])
    else $error("fault flag dropped without supply reset");
  a_fault_kills_out: assert property (fault_evt |=> !outputs_enable_o && fault_flag_o)
    else $error("outputs still enabled after protection event");
  a_deep_holds_pos: assert property (step_edge && deep_sleep && !q.filt[1] |=> $stable(q.pos))
    else $error("position moved in deep sleep");
  a_light_steps: assert property (s_active_edge ##0 light_sleep |=>
                                  q.pos != $past(q.pos) && !outputs_enable_o)
    else $error("light sleep blocked stepping or left outputs on");
  a_sixt_inc: assert property (s_sixt_fwd |=> q.pos == $past(q.pos) + 6'h01)
    else $error("sixteenth forward step not plus one");
  a_full_two_phase: assert property (s_active_edge ##0 (live_mode == SSS_MODE_FULL8)
                                     |=> ##1 two_phase_monitor_o == MICROSTEP)
    else $error("monitor wrong after full step");
  a_reset_restart: assert property (q.filt[1] |=> q.pos == `SSS_POS_INIT)
    else $error("reset pin did not restore initial position");
  a_filter_hold: assert property ($rose(q.filt[0]) |-> $past(q.s2[0], 1) && $past(q.s2[0], 2) &&
                                  $past(q.s2[0], 3) && $past(q.s2[0], 4) && $past(q.s2[0], 5))
    else $error("step input passed filter too early");
  a_sync_common: assert property (chop_sync_pulse_o |-> q.chop[0] == SSS_CHOP_OFF &&
                                  q.chop[1] == SSS_CHOP_OFF)
    else $error("sync chop did not turn both phases off");
  a_full_ratio: assert property (q.mode == SSS_MODE_FULLF && !q.filt[1] |->
                                 q.ph[0].ratio == `SSS_RATIO_FULL && q.ph[1].ratio == `SSS_RATIO_FULL)
    else $error("full ratio mode not at full current");

endmodule // sss_step_sequencer

`default_nettype wire

/* File: sim/sss_host.sv */
// host model: drives the step, direction, mode and reset pins
// assumes the bench calls its tasks just after a core clock edge
`timescale 1ns/1ps
`default_nettype none
module sss_host (
  input  wire logic  clk_i,
  output logic       step_o,
  output logic       dir_o,
  output logic [2:0] m_o,
  output logic       rstp_o
);
  localparam int HOLD = 100; // 2 us of core clock
  initial step_o = 1'b0;
  initial {rstp_o, m_o, dir_o} = 5'h00;
  task automatic pins(input logic d, input logic [2:0] m);
    @(posedge clk_i);
    {m_o, dir_o} <= {m, d};
    repeat (60) @(posedge clk_i); // settle through the input filter first
  endtask
  task automatic step(input logic d, input logic [2:0] m);
    pins(d, m);
    step_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    step_o <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
  endtask
  task automatic glitch();
    @(posedge clk_i);
    step_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    step_o <= 1'b0;
  endtask
  task automatic rst_pulse();
    @(posedge clk_i);
    rstp_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    rstp_o <= 1'b0;
    repeat (300) @(posedge clk_i);
  endtask
  task automatic wake();
    repeat (5000) @(posedge clk_i);
  endtask
endmodule // sss_host
`default_nettype wire

/* File: sim/tb.sv */
// bench: host model steps the sequencer, AXI4-Lite reads its status
// assumes default parameters: microstep variant, rising-edge stepping
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sss_pkg::*;
  localparam logic [2:0] CODE [7] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5};
  localparam logic [5:0] POS [7] = '{6'h18, 6'h28, 6'h30, 6'h38, 6'h3c, 6'h3e, 6'h3f};
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, chop_sync_i = 1'b0;
  logic        over_temperature_shutdown_i = 1'b0, current_reference_sleep_input_i = 1'b0;
  logic [1:0]  current_trip_i = 2'h0, coil_open_i = 2'h0, rsp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  wire logic   step_clock_i, reset_pin_i, direction_select_i;
  wire logic [2:0] md;
  sss_phase_t  phase_a_o, phase_b_o;
  logic        outputs_enable_o, two_phase_monitor_o, fault_flag_o, chop_sync_pulse_o;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          mismatches = 0, total_checks = 0, n;

  sss_step_sequencer dut (.*, .mode_select_0_i(md[0]), .mode_select_1_i(md[1]), .mode_select_2_i(md[2]));
  sss_host h (.clk_i(core_clk_i), .step_o(step_clock_i), .dir_o(direction_select_i), .m_o(md),
    .rstp_o(reset_pin_i));
  always #10 core_clk_i = ~core_clk_i; // 50 MHz

  // ----------
  // tasks
  // ----------
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask
  task automatic rst();
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(20);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // valid and payload stay up until their own ready is seen at an edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic stat(input logic [5:0] p, input logic [2:0] m);
    axr(8'h04);
    chk("pos", 8'(p), 8'(rdat[5:0]));
    chk("mode", 8'(m), 8'(rdat[8:6]));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------
  // tests
  // ----------
  initial begin
    cyc(50000);
    mismatches++;
    report_and_stop();
  end
  initial begin
    rst();
    stat(6'h08, 3'h0);
    h.step(1'b0, 3'h0);
    stat(6'h18, 3'h0);
    chk("ratio_a", 8'hb4, phase_a_o.ratio);
    chk("neg_a", 8'h1, 8'(phase_a_o.neg));
    chk("drv_b", 8'h1, 8'(phase_b_o.drive));
    h.step(1'b1, 3'h0);
    h.step(1'b1, 3'h0);
    stat(6'h38, 3'h0);
    h.step(1'b0, 3'h1);
    chk("ratio_b", 8'hff, phase_b_o.ratio);
    for (int i = 0; i < 7; i++) begin
      h.step(1'b0, 3'(i));
      stat(POS[i], CODE[i]);
      chk("mon", 8'(POS[i][3:0] == 4'h8), 8'(two_phase_monitor_o));
    end
    h.step(1'b0, 3'h6);
    stat(6'h00, 3'h5);
    h.pins(1'b1, 3'h1);
    stat(6'h00, 3'h5);
    h.glitch();
    cyc(50);
    stat(6'h00, 3'h5);
    $display("test modes end");
    current_reference_sleep_input_i <= 1'b1;
    cyc(20);
    chk("en", 8'h0, 8'(outputs_enable_o));
    h.step(1'b0, 3'h6);
    stat(6'h01, 3'h5);
    current_reference_sleep_input_i <= 1'b0;
    h.wake();
    h.pins(1'b0, 3'h7);
    chk("en", 8'h0, 8'(outputs_enable_o));
    h.step(1'b0, 3'h7);
    axr(8'h04);
    chk("pos", 8'h01, 8'(rdat[5:0]));
    h.pins(1'b0, 3'h6);
    h.wake();
    chk("en", 8'h1, 8'(outputs_enable_o));
    h.rst_pulse();
    stat(6'h08, 3'h0);
    $display("test sleep end");
    axw(8'h00, 32'h1);
    cyc(5);
    chk("en", 8'h0, 8'(outputs_enable_o));
    axr(8'h00);
    chk("ctrl", 8'h01, rdat[7:0]);
    axw(8'h04, 32'hffffffff);
    chk("bresp", 8'h00, 8'(rsp));
    axw(8'h00, 32'h0);
    axr(8'h08);
    chk("rresp", 8'h03, 8'(rsp));
    chk("rdata", 8'h00, rdat[7:0]);
    stat(6'h08, 3'h0);
    $display("test bus end");
    chop_sync_i <= 1'b1; // held at a two-phase position
    current_trip_i <= 2'h1;
    n = 0;
    while (chop_sync_pulse_o !== 1'b1 && n < 800) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("sync", 8'h1, 8'(chop_sync_pulse_o));
    chk("drv_a", 8'h0, 8'(phase_a_o.drive));
    current_trip_i <= 2'h0;
    chop_sync_i <= 1'b0;
    cyc(590);
    chk("drv_a", 8'h0, 8'(phase_a_o.drive));
    cyc(20);
    chk("drv_a", 8'h1, 8'(phase_a_o.drive));
    coil_open_i <= 2'h1;
    cyc(10);
    chk("flag", 8'h1, 8'(fault_flag_o));
    chk("en", 8'h0, 8'(outputs_enable_o));
    chk("drv_a", 8'h0, 8'(phase_a_o.drive));
    coil_open_i <= 2'h0;
    h.step(1'b0, 3'h0);
    chk("flag", 8'h1, 8'(fault_flag_o));
    rst();
    chk("flag", 8'h0, 8'(fault_flag_o));
    over_temperature_shutdown_i <= 1'b1;
    cyc(10);
    over_temperature_shutdown_i <= 1'b0;
    cyc(10);
    chk("flag", 8'h1, 8'(fault_flag_o));
    chk("en", 8'h0, 8'(outputs_enable_o));
    $display("test protection end");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
